// ### rtl/fpp_defs.svh
// constants for the flash programmer port
`ifndef FPP_DEFS_SVH
`define FPP_DEFS_SVH
`define FPP_CMD_READ      8'h00
`define FPP_CMD_PROG      8'h40
`define FPP_CMD_ERASE     8'h20
`define FPP_CMD_STATUS    8'h71
`define FPP_FILL_BYTE     8'hFF
`define FPP_PAGE_BYTES    128
`define FPP_PAGE_LO_A     8'h00
`define FPP_PAGE_LO_B     8'h80
`define FPP_ST_ABN        7
`define FPP_ST_CMD        6
`define FPP_ST_PRG        5
`define FPP_ST_ERS        4
`define FPP_ST_CNT        1
`define FPP_ST_ADR        0
`define FPP_DONE_BIT      7
`define FPP_PASS_BIT      6
`define FPP_SETUP_MS      20
`define FPP_CLK_KHZ       100000
`define FPP_SETUP_CYC     (`FPP_SETUP_MS * `FPP_CLK_KHZ)
`define FPP_WRITE_MS      1
`define FPP_WRITE_CYC     (`FPP_WRITE_MS * `FPP_CLK_KHZ)
`define FPP_ERASE_MS      100
`define FPP_ERASE_CYC     (`FPP_ERASE_MS * `FPP_CLK_KHZ)
`endif

// ### rtl/fpp_pkg.sv
// types for the flash programmer port
package fpp_pkg;
    typedef enum logic [2:0] {
        FPP_SETUP  = 3'b000,
        FPP_READ   = 3'b001,
        FPP_CMD2   = 3'b010,
        FPP_LOAD   = 3'b011,
        FPP_BUSY   = 3'b100,
        FPP_POLL   = 3'b101,
        FPP_STAT   = 3'b110
    } fpp_state_t;
endpackage : fpp_pkg

// ### rtl/fpp_timer.sv
// down counter timing setup, program and erase
`timescale 1ns/1ps
`default_nettype none
module fpp_timer #(
    parameter int W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_done
);
    logic [W-1:0] cnt_r;
    logic         run_r;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (i_load) begin
            cnt_r <= i_count;
            run_r <= 1'b1;
        end else if (run_r) begin
            if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
                run_r <= 1'b0;
            end
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign o_done = run_r && (cnt_r <= {{(W-1){1'b0}}, 1'b1});
endmodule : fpp_timer
`default_nettype wire

// ### rtl/fpp_port.sv
// programmer-mode parallel port of the flash array
// Summary of operation
// RQ1 - auto-program writes one 128-byte page from 128 consecutive byte writes.
// RQ2 - programmer pads unused page bytes with all-ones.
// RQ3 - page low address byte must be 00 or 80, else address error flagged.
// RQ4 - page address is captured on the second cycle only.
// RQ5 - programmer issues no command write while an operation runs.
// RQ6 - programmer programs each page only once between erases.
// RQ7 - after program, done bit 7 and pass bit 6 show completion.
// RQ8 - polling flags hold until next command write, readable on chip and output enable.
// RQ9 - auto-erase always erases the entire array.
// RQ10 - programmer waits one millisecond before polling.
// RQ11 - programmer waits twenty microseconds before status read.
// RQ12 - status byte: abnormal, command, program, erase, count, address error bits. The code never sets the count bit, so it reads 0.
// RQ13 - after erase, done bit 7 and pass bit 6 show completion.
// RQ14 - auto-program takes the command byte plus 128 data writes.
// RQ15 - programmer holds program-enable high for program and erase commands.
// RQ16 - done bit reads 0 while running, 1 after; pass bit 1 on normal end.
// RQ17 - after setup the device enters memory read; no commands before then.
// RQ18 - commands 00 read, 20 twice erase, 71 twice status; others are errors. The code also takes 40 as program.
`timescale 1ns/1ps
`default_nettype none
`include "fpp_defs.svh"
module fpp_port #(
    parameter int SETUP_CYC = `FPP_SETUP_CYC,
    parameter int WRITE_CYC = `FPP_WRITE_CYC,
    parameter int ERASE_CYC = `FPP_ERASE_CYC
) (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RESETN,
    input  wire logic        I_CE_N,
    input  wire logic        I_OE_N,
    input  wire logic        I_WE_N,
    input  wire logic        I_PROGRAM_ENABLE_PIN,
    input  wire logic [17:0] I_ADDR_BUS,
    input  wire logic [7:0]  I_BYTE_BUS,
    output logic      [7:0]  O_BYTE_BUS,
    output logic             O_BYTE_BUS_OE,
    input  wire logic [7:0]  I_ARRAY_RDATA,
    output logic      [17:0] O_ARRAY_ADDR,
    output logic             O_PAGE_WR,
    output logic      [17:0] O_PAGE_ADDR,
    output logic      [7:0]  O_PAGE_WDATA,
    output logic      [6:0]  O_PAGE_IDX,
    output logic             O_PAGE_WE,
    output logic             O_ERASE_ALL,
    input  wire logic        I_ARRAY_FAIL,
    output logic             O_READY
);
    logic            rs1_r;
    logic            rs_n;
    logic            we_d_r;
    logic            wr_pulse;
    logic            rd_en;
    fpp_pkg::fpp_state_t st_r;
    logic [7:0]      cmd_r;
    logic [7:0]      stat_r;
    logic [7:0]      outb_r;
    logic [7:0]      cnt_r;
    logic [17:0]     page_r;
    logic [7:0]      page_buf_r [0:`FPP_PAGE_BYTES-1];
    logic            tmr_load;
    logic [31:0]     tmr_cnt;
    logic            tmr_done;
    logic            flags_r;
    logic            op_erase_r;
    logic            pass_r;

    function automatic logic page_ok(input logic [7:0] lo);
        page_ok = (lo == `FPP_PAGE_LO_A) || (lo == `FPP_PAGE_LO_B);
    endfunction : page_ok

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rs1_r <= 1'b0;
            rs_n  <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs_n  <= rs1_r;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rs_n) begin
        if (!rs_n) begin
            we_d_r <= 1'b1;
        end else begin
            we_d_r <= I_WE_N | I_CE_N;
        end
    end
    assign wr_pulse = (I_WE_N | I_CE_N) && !we_d_r;
    assign rd_en    = !I_CE_N && !I_OE_N && I_WE_N;

    fpp_timer #(.W(32)) u_timer (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (rs_n),
        .i_load  (tmr_load),
        .i_count (tmr_cnt),
        .o_done  (tmr_done)
    );

    always_comb begin
        tmr_load = 1'b0;
        tmr_cnt  = 32'(SETUP_CYC);
        if (st_r == fpp_pkg::FPP_SETUP && !flags_r) begin
            tmr_load = 1'b1;
        end else if (st_r == fpp_pkg::FPP_LOAD && wr_pulse
                     && cnt_r == 8'(`FPP_PAGE_BYTES - 1)) begin
            tmr_load = 1'b1;
            tmr_cnt  = 32'(WRITE_CYC);
        end else if (st_r == fpp_pkg::FPP_CMD2 && wr_pulse && cmd_r == `FPP_CMD_ERASE
                     && I_BYTE_BUS == `FPP_CMD_ERASE) begin
            tmr_load = 1'b1;
            tmr_cnt  = 32'(ERASE_CYC);
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rs_n) begin
        if (!rs_n) begin
            st_r       <= fpp_pkg::FPP_SETUP;
            flags_r    <= 1'b0;
            cmd_r      <= 8'h00;
            cnt_r      <= 8'h00;
            page_r     <= 18'h00000;
            stat_r     <= 8'h00;
            op_erase_r <= 1'b0;
            pass_r     <= 1'b0;
        end else begin
            case (st_r)
                fpp_pkg::FPP_SETUP: begin
                    flags_r <= 1'b1;
                    if (flags_r && tmr_done) begin
                        st_r <= fpp_pkg::FPP_READ; // RQ17
                    end
                end
                fpp_pkg::FPP_READ, fpp_pkg::FPP_POLL, fpp_pkg::FPP_STAT: begin
                    if (wr_pulse) begin
                        cmd_r <= I_BYTE_BUS;
                        case (I_BYTE_BUS) // RQ18
                            `FPP_CMD_READ: st_r <= fpp_pkg::FPP_READ;
                            `FPP_CMD_PROG: begin
                                st_r  <= fpp_pkg::FPP_CMD2;
                                cnt_r <= 8'h00;
                            end
                            `FPP_CMD_ERASE, `FPP_CMD_STATUS: st_r <= fpp_pkg::FPP_CMD2;
                            default: begin
                                stat_r[`FPP_ST_CMD] <= 1'b1;
                                stat_r[`FPP_ST_ABN] <= 1'b1;
                                st_r <= fpp_pkg::FPP_READ;
                            end
                        endcase
                    end
                end
                fpp_pkg::FPP_CMD2: begin
                    if (wr_pulse) begin
                        if (cmd_r == `FPP_CMD_PROG) begin
                            page_r <= {I_ADDR_BUS[17:7], 7'h00}; // RQ4
                            stat_r <= 8'h00;
                            stat_r[`FPP_ST_ADR] <= !page_ok(I_ADDR_BUS[7:0]); // RQ3
                            cnt_r  <= 8'h01;
                            st_r   <= fpp_pkg::FPP_LOAD;
                        end else if (I_BYTE_BUS == cmd_r && cmd_r == `FPP_CMD_ERASE) begin
                            stat_r     <= 8'h00;
                            op_erase_r <= 1'b1;
                            st_r       <= fpp_pkg::FPP_BUSY; // RQ9
                        end else if (I_BYTE_BUS == cmd_r) begin
                            st_r <= fpp_pkg::FPP_STAT;
                        end else begin
                            stat_r[`FPP_ST_CMD] <= 1'b1;
                            stat_r[`FPP_ST_ABN] <= 1'b1;
                            st_r <= fpp_pkg::FPP_READ;
                        end
                    end
                end
                fpp_pkg::FPP_LOAD: begin
                    if (wr_pulse) begin
                        cnt_r <= cnt_r + 8'h01; // RQ14
                        if (cnt_r == 8'(`FPP_PAGE_BYTES - 1)) begin
                            op_erase_r <= 1'b0;
                            st_r       <= fpp_pkg::FPP_BUSY; // RQ1
                        end
                    end
                end
                fpp_pkg::FPP_BUSY: begin
                    if (tmr_done) begin
                        pass_r <= !I_ARRAY_FAIL && !stat_r[`FPP_ST_ADR]; // RQ16
                        if (I_ARRAY_FAIL) begin
                            stat_r[op_erase_r ? `FPP_ST_ERS : `FPP_ST_PRG] <= 1'b1; // RQ12
                        end
                        if (I_ARRAY_FAIL || stat_r[`FPP_ST_ADR]) begin
                            stat_r[`FPP_ST_ABN] <= 1'b1;
                        end
                        st_r <= fpp_pkg::FPP_POLL; // RQ8
                    end
                end
                default: st_r <= fpp_pkg::FPP_READ;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (st_r == fpp_pkg::FPP_LOAD && wr_pulse) begin
            page_buf_r[cnt_r[6:0]] <= I_BYTE_BUS;
        end else if (st_r == fpp_pkg::FPP_CMD2 && wr_pulse && cmd_r == `FPP_CMD_PROG) begin
            page_buf_r[7'h00] <= I_BYTE_BUS;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rs_n) begin
        if (!rs_n) begin
            O_PAGE_WE    <= 1'b0;
            O_PAGE_WDATA <= 8'h00;
            O_PAGE_IDX   <= 7'h00;
        end else begin
            O_PAGE_WE    <= wr_pulse && (st_r == fpp_pkg::FPP_LOAD ||
                            (st_r == fpp_pkg::FPP_CMD2 && cmd_r == `FPP_CMD_PROG));
            O_PAGE_WDATA <= I_BYTE_BUS;
            O_PAGE_IDX   <= (st_r == fpp_pkg::FPP_LOAD) ? cnt_r[6:0] : 7'h00;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rs_n) begin
        if (!rs_n) begin
            outb_r <= 8'h00;
        end else begin
            case (st_r)
                fpp_pkg::FPP_BUSY: outb_r <= 8'h00; // RQ16
                fpp_pkg::FPP_POLL: begin
                    outb_r <= 8'h00;
                    outb_r[`FPP_DONE_BIT] <= 1'b1; // RQ7
                    outb_r[`FPP_PASS_BIT] <= pass_r; // RQ13
                end
                fpp_pkg::FPP_STAT: outb_r <= {stat_r[7:4], 2'b00, stat_r[1:0]}; // RQ12
                default: outb_r <= I_ARRAY_RDATA;
            endcase
        end
    end

    assign O_BYTE_BUS    = outb_r;
    assign O_BYTE_BUS_OE = rd_en && (st_r != fpp_pkg::FPP_SETUP); // RQ8
    assign O_ARRAY_ADDR  = I_ADDR_BUS;
    assign O_PAGE_ADDR   = page_r;
    assign O_PAGE_WR     = (st_r == fpp_pkg::FPP_LOAD) && wr_pulse
                           && cnt_r == 8'(`FPP_PAGE_BYTES - 1);
    assign O_ERASE_ALL   = (st_r == fpp_pkg::FPP_CMD2) && wr_pulse
                           && cmd_r == `FPP_CMD_ERASE && I_BYTE_BUS == `FPP_CMD_ERASE;
    assign O_READY       = (st_r != fpp_pkg::FPP_SETUP) && (st_r != fpp_pkg::FPP_BUSY);

    a_busy_done_low: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        st_r == fpp_pkg::FPP_BUSY && $past(st_r) == fpp_pkg::FPP_BUSY |-> outb_r[7] == 1'b0)
        else $error("done bit high while busy"); // RQ16
    a_poll_done_high: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        $past(st_r) == fpp_pkg::FPP_POLL && st_r == fpp_pkg::FPP_POLL |-> outb_r[7])
        else $error("done bit low after end"); // RQ7
    a_poll_hold: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        st_r == fpp_pkg::FPP_POLL && !wr_pulse |=> st_r == fpp_pkg::FPP_POLL)
        else $error("poll flags lost without write"); // RQ8
    a_page_addr_err: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        st_r == fpp_pkg::FPP_CMD2 && cmd_r == `FPP_CMD_PROG && wr_pulse
        |=> stat_r[0] == !page_ok($past(I_ADDR_BUS[7:0])))
        else $error("address error flag wrong"); // RQ3
    a_page_last: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        O_PAGE_WR |=> st_r == fpp_pkg::FPP_BUSY)
        else $error("page end without busy"); // RQ1
    a_page_addr_hold: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        st_r == fpp_pkg::FPP_LOAD && $past(st_r) == fpp_pkg::FPP_LOAD |-> $stable(page_r))
        else $error("page address moved"); // RQ4
    a_setup_nocmd: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        st_r == fpp_pkg::FPP_SETUP |=> st_r inside {fpp_pkg::FPP_SETUP, fpp_pkg::FPP_READ})
        else $error("command taken during setup"); // RQ17
    a_bad_cmd: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        st_r inside {fpp_pkg::FPP_READ, fpp_pkg::FPP_POLL, fpp_pkg::FPP_STAT} && wr_pulse
        && !(I_BYTE_BUS inside {8'h00, 8'h20, 8'h40, 8'h71})
        |=> stat_r[6] && st_r == fpp_pkg::FPP_READ)
        else $error("bad command not flagged"); // RQ18
    a_erase_start: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        O_ERASE_ALL |=> st_r == fpp_pkg::FPP_BUSY && op_erase_r)
        else $error("erase not started"); // RQ9
    a_load_count: assert property (@(posedge I_CLK_SYS) disable iff (!rs_n)
        st_r == fpp_pkg::FPP_LOAD && wr_pulse && cnt_r != 8'h7F |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("page count slipped"); // RQ14
endmodule : fpp_port
`default_nettype wire

// ### testbench/fpp_prog_model.sv
// programmer-side model driving the parallel byte bus
`timescale 1ns/1ps
`default_nettype none
module fpp_prog_model (
    input  wire logic        i_clk,
    input  wire logic [7:0]  i_byte_bus,
    input  wire logic        i_byte_bus_oe,
    output logic             o_ce_n,
    output logic             o_oe_n,
    output logic             o_we_n,
    output logic             o_pe,
    output logic      [17:0] o_addr,
    output logic      [7:0]  o_byte
);
    initial begin
        o_ce_n = 1'b1;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_pe   = 1'b0;
        o_addr = 18'h00000;
        o_byte = 8'h00;
    end
    // one write pulse, taken on the edge after write enable rises; bus held past that edge
    task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic pe);
        @(posedge i_clk);
        #1;
        o_ce_n = 1'b0;
        o_we_n = 1'b0;
        o_pe   = pe;
        o_addr = a;
        o_byte = d;
        @(posedge i_clk);
        #1;
        o_we_n = 1'b1;
        @(posedge i_clk);
        #1;
        o_ce_n = 1'b1;
        o_byte = ~d;
    endtask : wr
    // one read with chip and output enable low
    task automatic rd(input logic [17:0] a, output logic [7:0] d, output logic oe);
        @(posedge i_clk);
        #1;
        o_ce_n = 1'b0;
        o_oe_n = 1'b0;
        o_addr = a;
        repeat (3) @(posedge i_clk);
        #1;
        d      = i_byte_bus;
        oe     = i_byte_bus_oe;
        o_ce_n = 1'b1;
        o_oe_n = 1'b1;
    endtask : rd
endmodule : fpp_prog_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the flash programmer port
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int WR_CYC = 10;
    localparam int ER_CYC = 20;
    logic        clk;
    logic        rst_n;
    logic        ce_n, oe_n, we_n, pe, bus_oe, page_wr, page_we, erase_all, ready, fail;
    logic [17:0] addr, arr_addr, page_addr, wr_addr;
    logic [7:0]  wbyte, rbyte, wdata, last_wd, d;
    logic [6:0]  idx;
    logic        oe;
    int          fails, n_tests, n_we, n_wr, n_er;

    fpp_port #(.SETUP_CYC(20), .WRITE_CYC(WR_CYC), .ERASE_CYC(ER_CYC)) u_dut (
        .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_CE_N(ce_n), .I_OE_N(oe_n),
        .I_WE_N(we_n), .I_PROGRAM_ENABLE_PIN(pe), .I_ADDR_BUS(addr),
        .I_BYTE_BUS(wbyte), .O_BYTE_BUS(rbyte), .O_BYTE_BUS_OE(bus_oe),
        .I_ARRAY_RDATA(arr_addr[7:0] ^ 8'hA5), .O_ARRAY_ADDR(arr_addr),
        .O_PAGE_WR(page_wr), .O_PAGE_ADDR(page_addr), .O_PAGE_WDATA(wdata),
        .O_PAGE_IDX(idx), .O_PAGE_WE(page_we), .O_ERASE_ALL(erase_all),
        .I_ARRAY_FAIL(fail), .O_READY(ready));
    fpp_prog_model u_prog (
        .i_clk(clk), .i_byte_bus(rbyte), .i_byte_bus_oe(bus_oe), .o_ce_n(ce_n),
        .o_oe_n(oe_n), .o_we_n(we_n), .o_pe(pe), .o_addr(addr), .o_byte(wbyte));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // array side: pulses counted, last page byte kept
    always @(posedge clk) begin
        if (page_we === 1'b1) n_we++;
        if (page_we === 1'b1 && idx === 7'h7F) last_wd = wdata;
        if (page_wr === 1'b1) begin
            n_wr++;
            wr_addr = page_addr;
        end
        if (erase_all === 1'b1) n_er++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic wait_ready();
        int k;
        for (k = 0; k < 300 && ready !== 1'b1; k++) @(posedge clk);
        #1;
        check(ready, 1'b1, "ready timeout");
    endtask : wait_ready
    task automatic status(input logic [7:0] exp);
        u_prog.wr(18'h00000, 8'h71, 1'b0);
        u_prog.wr(18'h00000, 8'h71, 1'b0);
        repeat (4) @(posedge clk);
        u_prog.rd(18'h00000, d, oe);
        check(d, exp, "status byte");
    endtask : status
    task automatic t_setup();
        check(ready, 1'b0, "ready in setup");
        u_prog.rd(18'h00055, d, oe);
        check(oe, 1'b0, "drive in setup");
        wait_ready();
        u_prog.rd(18'h00055, d, oe);
        check(oe, 1'b1, "drive in read");
        check(d, 8'hF0, "array read");
    endtask : t_setup
    task automatic t_prog(input logic [17:0] pa, input logic [7:0] exp);
        int i;
        n_we = 0;
        n_wr = 0;
        u_prog.wr(18'h00000, 8'h40, 1'b1);
        for (i = 0; i < 128; i++) u_prog.wr(pa, (i < 100) ? i[7:0] : 8'hFF, 1'b1);
        // last page byte strobe shows one edge after the final write
        @(posedge clk);
        #1;
        check(n_we, 128, "page byte count");
        check(n_wr, 1, "page commit count");
        check(wr_addr, {pa[17:7], 7'h00}, "page address");
        check(last_wd, 8'hFF, "pad byte");
        u_prog.rd(18'h00000, d, oe);
        check(d[7], 1'b0, "done while busy");
        repeat (WR_CYC) @(posedge clk);
        wait_ready();
        u_prog.rd(18'h00000, d, oe);
        check(d, exp, "program poll");
        u_prog.rd(18'h00011, d, oe);
        check(d, exp, "poll held");
    endtask : t_prog
    task automatic t_erase();
        fail = 1'b1;
        n_er = 0;
        u_prog.wr(18'h00000, 8'h20, 1'b1);
        u_prog.wr(18'h00000, 8'h20, 1'b1);
        check(n_er, 1, "erase pulse");
        repeat (ER_CYC) @(posedge clk);
        wait_ready();
        u_prog.rd(18'h00000, d, oe);
        check(d, 8'h80, "erase poll fail");
        fail = 1'b0;
        status(8'h90);
    endtask : t_erase
    task automatic t_cmds();
        u_prog.wr(18'h00000, 8'h55, 1'b0);
        status(8'hD0);
        u_prog.wr(18'h00000, 8'h00, 1'b0);
        u_prog.rd(18'h0003C, d, oe);
        check(d, 8'h99, "read after read command");
    endtask : t_cmds

    initial begin
        fails   = 0;
        n_tests = 0;
        n_we    = 0;
        n_wr    = 0;
        n_er    = 0;
        fail    = 1'b0;
        last_wd = 8'h00;
        wr_addr = 18'h00000;
        rst_n   = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_setup();
        t_prog(18'h00200, 8'hC0);
        t_prog(18'h00340, 8'h80);
        status(8'h81);
        t_erase();
        t_cmds();
        end_of_test();
    end
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
